// ---- core/hcc_classifier.sv ----
/*
 Host completion code classifier: turns each finished transaction's
 outcome flags into a 3-bit completion code.
 Assumes flags are valid with i_done, from logic on i_clk.
*/
// Contract
// - Short IN packet under budget gives code 011
// - CRC or stuff error beats size codes
// - Toggle mismatch beats overrun when size ok
// - Timeout after IN or OUT gives 100
// - CRC failure gives retry-error code
// - Bit-stuffing violation gives retry-error code
// - PID check bits failure gives retry error
// - Invalid or undefined PID gives retry error
// - Split interrupt ERR handshake gives retry error
// - Third consecutive split NYET gives retry error
// - Data toggle mismatch gives retry error
// - No error gives code 000
// - Stall handshake gives code 001
// - Oversize IN packet or IN over budget gives 010
`timescale 1ns/100ps

module hcc_classifier
    import hcc_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire logic                   i_srst,
    input  wire logic                   i_done,
    input  wire hcc_pkg::hcc_kind_t     i_kind,
    input  wire logic [hcc_pkg::HCC_SIZE_W-1:0]  i_max_packet_size,
    input  wire logic [hcc_pkg::HCC_SIZE_W-1:0]  i_packet_len,
    input  wire logic [hcc_pkg::HCC_TOTAL_W-1:0] i_transfer_byte_budget,
    input  wire logic [hcc_pkg::HCC_TOTAL_W-1:0] i_bytes_received,
    input  wire logic                   i_timeout,
    input  wire logic                   i_crc_err,
    input  wire logic                   i_stuff_err,
    input  wire logic                   i_pid_check_err,
    input  wire logic                   i_pid_invalid,
    input  wire logic                   i_toggle_mismatch,
    input  wire logic                   i_stall,
    input  wire logic                   i_split_intr,
    input  wire logic                   i_hub_err,
    input  wire logic                   i_nyet,
    output hcc_pkg::hcc_code_t          o_code,
    output logic                        o_code_valid
);

    import hcc_pkg::*;

    hcc_code_t code_r;
    hcc_code_t code_nxt;
    logic      valid_r;
    logic      valid_nxt;
    logic      nyet_limit;
    logic      data_in;
    logic      pkt_over;
    logic      pkt_short;
    logic      bytes_over;
    logic      bytes_under;
    logic      link_fault;

    // ----------------------------------------
    // Split NYET run
    // ----------------------------------------
    hcc_nyet_counter u_nyet
    (
        .i_clk        (i_clk),
        .i_srst       (i_srst),
        .i_done       (i_done),
        .i_split_intr (i_split_intr),
        .i_nyet       (i_nyet),
        .o_limit      (nyet_limit)
    );

    // ----------------------------------------
    // Size comparisons
    // ----------------------------------------
    assign data_in     = (i_kind == HCC_KIND_IN);
    assign pkt_over    = data_in && (i_packet_len > i_max_packet_size);
    assign pkt_short   = data_in && (i_packet_len < i_max_packet_size);
    assign bytes_over  = data_in && (i_bytes_received > i_transfer_byte_budget);
    assign bytes_under = data_in && (i_bytes_received < i_transfer_byte_budget);

    // Corrupt packets make the size count untrustworthy, hence they win
    assign link_fault = i_crc_err
        || i_stuff_err
        || i_pid_check_err
        || i_pid_invalid
        || (i_split_intr && i_hub_err)
        || nyet_limit
        || i_timeout;

    // ----------------------------------------
    // Classification
    // ----------------------------------------
    always_comb
    begin
        code_nxt  = code_r;
        valid_nxt = 1'b0;
        if (i_done)
        begin
            valid_nxt = 1'b1;
            if (link_fault)
                code_nxt = TRANSIENT_FAULT_CODE;
            else if (i_stall)
                code_nxt = STALL_CODE;
            else if (i_toggle_mismatch && !pkt_over)
                code_nxt = TRANSIENT_FAULT_CODE;
            else if (pkt_over || bytes_over)
                code_nxt = EXCESS_BYTES_CODE;
            else if (i_toggle_mismatch)
                code_nxt = TRANSIENT_FAULT_CODE;
            else if (pkt_short && bytes_under)
                code_nxt = SHORT_PACKET_CODE;
            else
                code_nxt = CLEAN_COMPLETION_CODE;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            code_r  <= CLEAN_COMPLETION_CODE;
            valid_r <= 1'b0;
        end
        else
        begin
            code_r  <= code_nxt;
            valid_r <= valid_nxt;
        end
    end

    assign o_code       = code_r;
    assign o_code_valid = valid_r;

endmodule

// ---- core/hcc_pkg.sv ----
/*
 Package for the host completion code classifier: codes, widths, limits.
 Assumes one controller clock domain; no software registers.
*/
package hcc_pkg;

    localparam int          HCC_CODE_W     = 3;
    localparam int          HCC_SIZE_W     = 11;
    localparam int          HCC_TOTAL_W    = 20;
    localparam int          HCC_NYET_W     = 2;
    localparam logic [1:0]  HCC_NYET_LIMIT = 2'h3;

    typedef logic [HCC_CODE_W-1:0] hcc_code_t;

    localparam hcc_code_t CLEAN_COMPLETION_CODE = 3'h0;
    localparam hcc_code_t STALL_CODE            = 3'h1;
    localparam hcc_code_t EXCESS_BYTES_CODE     = 3'h2;
    localparam hcc_code_t SHORT_PACKET_CODE     = 3'h3;
    localparam hcc_code_t TRANSIENT_FAULT_CODE  = 3'h4;

    typedef enum logic [1:0] {
        HCC_KIND_IN,
        HCC_KIND_OUT,
        HCC_KIND_OTHER
    } hcc_kind_t;

endpackage

// ---- core/hcc_nyet_counter.sv ----
/*
 Consecutive NYET counter for split interrupt transfers.
 Assumes strobes come from the host transaction engine on i_clk.
*/
`timescale 1ns/100ps

module hcc_nyet_counter
    import hcc_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_srst,
    input  wire logic i_done,
    input  wire logic i_split_intr,
    input  wire logic i_nyet,
    output logic      o_limit
);

    logic [HCC_NYET_W-1:0] count_r;
    logic [HCC_NYET_W-1:0] count_nxt;
    logic [HCC_NYET_W-1:0] count_inc;

    assign count_inc = count_r + 2'h1;
    // Third in a row reaches the limit
    assign o_limit   = i_done && i_split_intr && i_nyet && (count_inc == HCC_NYET_LIMIT);

    // ----------------------------------------
    // Next count
    // ----------------------------------------
    always_comb
    begin
        count_nxt = count_r;
        if (i_done)
        begin
            // Any other outcome breaks the run
            if (i_split_intr && i_nyet && !o_limit)
                count_nxt = count_inc;
            else
                count_nxt = '0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            count_r <= '0;
        else
            count_r <= count_nxt;
    end

endmodule

// ---- testbench/hcc_chk.sv ----
/* Port checks for hcc_classifier.
   Assumes one clock and a synchronous reset. */
`timescale 1ns/100ps
module hcc_chk(
    input logic       i_clk,
    input logic       i_srst,
    input logic       i_done,
    input logic       i_timeout,
    input logic       i_crc_err,
    input logic       i_stall,
    input logic [2:0] o_code,
    input logic       o_code_valid
);
    // ----
    // Checks
    // ----
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    a_valid_next: assert property (i_done |=> o_code_valid) else $error("late valid");
    a_valid_once: assert property (!i_done |=> !o_code_valid) else $error("extra valid");
    a_code_hold: assert property (!i_done |=> $stable(o_code)) else $error("code moved");
    a_timeout_code: assert property (i_done && i_timeout |=> o_code == 3'h4) else $error("timeout");
    a_crc_code: assert property (i_done && i_crc_err |=> o_code == 3'h4) else $error("crc");
    a_crc_over_stall: assert property (i_done && i_crc_err && i_stall |=> o_code == 3'h4) else $error("prio");
    a_stall_code: assert property (i_done && i_stall |=> o_code inside {3'h1, 3'h4}) else $error("stall");
    a_code_range: assert property (o_code_valid |-> o_code <= 3'h4) else $error("range");
    c_stall: cover property (i_done && i_stall);
    c_crc: cover property (i_done && i_crc_err);
    c_short: cover property (o_code_valid && o_code == 3'h3);
endmodule
bind hcc_classifier hcc_chk u_hcc_chk(.*);

// ---- testbench/hcc_ep_model.sv ----
/* Endpoint model: reports a transfer one or two cycles after i_go.
   Assumes i_go is a one-cycle strobe. */
`timescale 1ns/100ps
module hcc_ep_model(
    input  wire logic       i_clk,
    input  wire logic       i_go,
    input  wire logic       i_slow,
    input  wire logic [9:0] i_fl,
    output logic            o_done = 1'b0,
    output logic [9:0]      o_fl = 10'h0
);
    logic [1:0] cnt_r = 2'h0;
    // ----
    // Reply timing
    // ----
    always @(posedge i_clk) cnt_r <= i_go ? {i_slow, ~i_slow} : cnt_r >> 1;
    // Stale flags would hide a missed i_done, so invert them
    always @(negedge i_clk)
    begin
        o_done <= cnt_r == 2'h1;
        o_fl <= cnt_r == 2'h1 ? i_fl : ~i_fl;
    end
endmodule

// ---- testbench/tb_top.sv ----
/* Bench for hcc_classifier fed by the endpoint model.
   Assumes results one cycle after i_done. */
`timescale 1ns/100ps
`define CHK(n,e,a) begin checks++; if ((a)!==(e)) begin err_total++; $display("mismatch %s exp %h got %h",n,e,a); end end
module tb_top;
    import hcc_pkg::*;
    logic        i_clk = 1'b0, i_srst = 1'b1, i_done, o_code_valid, go = 1'b0, slow = 1'b0;
    logic        i_timeout, i_crc_err, i_stuff_err, i_pid_check_err, i_pid_invalid, i_toggle_mismatch;
    logic        i_stall, i_split_intr, i_hub_err, i_nyet;
    logic [9:0]  fl = 10'h0;
    logic [10:0] i_max_packet_size = 11'h40, i_packet_len = 11'h0;
    logic [19:0] i_transfer_byte_budget = 20'h64, i_bytes_received = 20'h0;
    hcc_kind_t   i_kind = HCC_KIND_IN;
    hcc_code_t   o_code;
    int          err_total = 0, checks = 0;
    always #12.5 i_clk = ~i_clk;
    hcc_ep_model u_hcc_ep_model(.i_clk(i_clk), .i_go(go), .i_slow(slow), .i_fl(fl), .o_done(i_done), .o_fl({i_timeout,
        i_crc_err, i_stuff_err, i_pid_check_err, i_pid_invalid, i_toggle_mismatch, i_stall, i_split_intr, i_hub_err, i_nyet}));
    hcc_classifier u_hcc_classifier(.*);
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic xfer(input logic [9:0] f, input logic [10:0] n, input logic [19:0] b, input hcc_code_t e);
        int k = 0;
        @(negedge i_clk);
        {fl, i_packet_len, i_bytes_received, slow, go} = {f, n, b, ~slow, 1'b1};
        @(negedge i_clk) go = 1'b0;
        while (o_code_valid !== 1'b1 && k++ < 20) @(posedge i_clk) #1;
        `CHK("o_code", e, o_code)
    endtask
    task automatic t_size;
        xfer(10'h0, 11'h40, 20'h40, 3'h0);
        xfer(10'h0, 11'ha, 20'ha, 3'h3);
        xfer(10'h0, 11'h41, 20'h41, 3'h2);
        xfer(10'h0, 11'h20, 20'h65, 3'h2);
        @(negedge i_clk) i_kind = HCC_KIND_OUT;
        xfer(10'h0, 11'ha, 20'ha, 3'h0);
        xfer(10'h0, 11'h41, 20'h65, 3'h0);
        xfer(10'h200, 11'ha, 20'ha, 3'h4);
        @(negedge i_clk) i_kind = HCC_KIND_IN;
        $display("size test done");
    endtask
    task automatic t_err;
        for (int i = 5; i < 10; i++) xfer(10'h1 << i, 11'ha, 20'ha, 3'h4);
        xfer(10'h100, 11'h41, 20'h41, 3'h4);
        xfer(10'h10, 11'h40, 20'h65, 3'h4);
        xfer(10'h108, 11'ha, 20'ha, 3'h4);
        xfer(10'h8, 11'ha, 20'ha, 3'h1);
        @(negedge i_clk) i_srst = 1'b1;
        @(negedge i_clk) i_srst = 1'b0;
        `CHK("o_code", 3'h0, o_code)
        $display("error test done");
    endtask
    task automatic t_split;
        xfer(10'h6, 11'h40, 20'h40, 3'h4);
        for (int i = 0; i < 6; i++) xfer(10'h5, 11'h40, 20'h40, i % 3 == 2 ? 3'h4 : 3'h0);
        $display("split test done");
    endtask
    initial
    begin
        repeat (10) @(negedge i_clk);
        i_srst = 1'b0;
        t_size;
        t_err;
        t_split;
        finish_test;
    end
    // About 25 transfers of at most 5 cycles, with wide margin
    initial
    begin
        #50000 err_total++;
        finish_test;
    end
endmodule
